// >>> hdl/wdt_top.v
// Watchdog timer with prewarning interrupt and delayed reset request
// How it works
// - After chip reset the counter runs without any software enable.
// - Disable and enable instructions stop or restart the watchdog at any time.
// - On overflow a prewarning is raised first, then a reset request.
// - The count register is sixteen bits; overflow is its wrap past all ones.
// - A prescaler divides the system clock by 16384 or by 256.
// - Reload loads the counter from a programmable reload value.
// - Each service reloads the counter and clears the prescaler.
// - Reset defaults give a 6.5 ms interval at 10 MHz.
`timescale 1ns/1ns
`include "wdt_defs.vh"
module wdt_top #(
  parameter CNT_W = 16,
  parameter [7:0] WARN_TICKS = `WDT_WARN_TICKS
) (
  // Clock and reset
  input wire clock,
  input wire rst,
  // Processor instruction strobes
  input wire watchdog_disable_instruction,
  input wire watchdog_enable_instruction,
  input wire service,
  // Configuration written by software
  input wire reload_write,
  input wire [7:0] watchdog_reload_value_in,
  input wire prescale_write,
  input wire prescale_fast_in,
  // Status and requests
  output reg running,
  output reg [CNT_W-1:0] count,
  output reg prewarn_irq,
  output reg reset_request,
  output reg [7:0] watchdog_reload_value,
  output reg prescale_fast
);
  localparam ST_COUNT = 2'b00;
  localparam ST_WARN = 2'b01;
  localparam ST_RESET = 2'b10;
  // Reset image of the counter, kept constant for the asynchronous reset branches
  localparam [31:0] DEF_RELOAD = `WDT_RESET_RELOAD;
  localparam [CNT_W-1:0] DEF_COUNT = DEF_RELOAD[CNT_W-1:0];
  localparam [7:0] DEF_RELOAD_BYTE = DEF_RELOAD[15:8];

  // Phase register and its next values
  reg [1:0] state;
  reg [1:0] next_state;
  reg [7:0] warn_left;
  reg [7:0] next_warn_left;
  reg next_prewarn_irq;
  reg next_reset_request;
  // Run control, counter and configuration next values
  reg next_running;
  reg [CNT_W-1:0] next_count;
  reg [7:0] next_reload_value;
  reg next_prescale_fast;
  wire tick;
  wire wrap;
  wire [CNT_W-1:0] reload_full;

  // Reload value fills the upper byte of the counter
  assign reload_full = {watchdog_reload_value, {(CNT_W-8){1'b0}}};
  assign wrap = tick && (count == {CNT_W{1'b1}});

  wdt_prescaler #(
    .PRE_W(`WDT_PRE_W)
  ) u_pre (
    .clock(clock),
    .rst(rst),
    .run(running),
    .clear(service),
    .sel_fast(prescale_fast),
    .tick(tick)
  );

  // Software configuration: reload byte and prescaler select
  always @* begin
    next_reload_value = watchdog_reload_value;
    next_prescale_fast = prescale_fast;
    if (reload_write) begin
      next_reload_value = watchdog_reload_value_in;
    end
    if (prescale_write) begin
      next_prescale_fast = prescale_fast_in;
    end
  end

  always @(posedge clock or posedge rst) begin
    if (rst) begin
      watchdog_reload_value <= DEF_RELOAD_BYTE;
      prescale_fast <= `WDT_RESET_FAST;
    end else begin
      watchdog_reload_value <= next_reload_value;
      prescale_fast <= next_prescale_fast;
    end
  end

  // Run control: disable wins when both instructions arrive together
  always @* begin
    next_running = running;
    if (watchdog_disable_instruction) begin
      next_running = 1'b0;
    end else if (watchdog_enable_instruction) begin
      next_running = 1'b1;
    end
  end

  always @(posedge clock or posedge rst) begin
    if (rst) begin
      running <= 1'b1;
    end else begin
      running <= next_running;
    end
  end

  // Counter: a service load wins; the prescaler holds back its tick in that cycle
  always @* begin
    next_count = count;
    if (service) begin
      next_count = reload_full;
    end else if (tick) begin
      next_count = count + 1'b1;
    end
  end

  always @(posedge clock or posedge rst) begin
    if (rst) begin
      count <= DEF_COUNT;
    end else begin
      count <= next_count;
    end
  end

  // Phase control: counting, prewarning, then a sticky reset request
  always @* begin
    next_state = state;
    next_warn_left = warn_left;
    next_prewarn_irq = 1'b0;
    next_reset_request = reset_request;
    // Disable leaves any phase; a raised reset request stays until rst
    if (watchdog_disable_instruction) begin
      next_state = ST_COUNT;
    end
    case (state)
      ST_COUNT: begin
        if (wrap && !service && !watchdog_disable_instruction) begin
          next_prewarn_irq = 1'b1;
          next_warn_left = WARN_TICKS;
          next_state = ST_WARN;
        end
      end
      ST_WARN: begin
        // Service does not end this phase; only disable or the last warning tick, which raises the reset request, does
        if (tick && !watchdog_disable_instruction) begin
          if (warn_left == 8'h01) begin
            next_reset_request = 1'b1;
            next_state = ST_RESET;
          end else begin
            next_warn_left = warn_left - 8'h01;
          end
        end
      end
      ST_RESET: begin
        next_reset_request = 1'b1;
      end
      default: begin
        next_state = ST_COUNT;
      end
    endcase
  end

  always @(posedge clock or posedge rst) begin
    if (rst) begin
      state <= ST_COUNT;
      warn_left <= 8'h00;
      prewarn_irq <= 1'b0;
      reset_request <= 1'b0;
    end else begin
      state <= next_state;
      warn_left <= next_warn_left;
      prewarn_irq <= next_prewarn_irq;
      reset_request <= next_reset_request;
    end
  end
endmodule

// >>> hdl/wdt_defs.vh
// Constants shared by the watchdog timer files
`ifndef WDT_DEFS_VH
`define WDT_DEFS_VH

`define WDT_CNT_W 16
`define WDT_PRE_W 14
`define WDT_DIV_SLOW 16384
`define WDT_DIV_FAST 256
`define WDT_CLK_HZ 10000000
`define WDT_INTERVAL_NS 6500000
`define WDT_CLK_NS 100
// Default interval counted in system clocks: 6.5 ms at 100 ns per clock
`define WDT_INTERVAL_CLKS (`WDT_INTERVAL_NS / `WDT_CLK_NS)
// Ticks in the default interval with the fast prescaler, rounded down
`define WDT_DEF_TICKS (`WDT_INTERVAL_CLKS / `WDT_DIV_FAST)
`define WDT_RESET_FAST 1'b1
// Reload value leaving WDT_DEF_TICKS ticks before the counter wraps
`define WDT_RESET_RELOAD (17'h10000 - `WDT_DEF_TICKS)
`define WDT_WARN_TICKS 8'h10

`endif

// >>> hdl/wdt_prescaler.v
// Watchdog prescaler: one tick per 16384 or per 256 system clocks
`timescale 1ns/1ns
`include "wdt_defs.vh"
module wdt_prescaler #(
  parameter PRE_W = 14
) (
  // Clock and reset
  input wire clock,
  input wire rst,
  // Control
  input wire run,
  input wire clear,
  input wire sel_fast,
  // Tick
  output wire tick
);
  localparam [31:0] LIMIT_FAST = `WDT_DIV_FAST - 1;
  localparam [31:0] LIMIT_SLOW = `WDT_DIV_SLOW - 1;

  reg [PRE_W-1:0] count;
  wire [PRE_W-1:0] limit;

  assign limit = sel_fast ? LIMIT_FAST[PRE_W-1:0] : LIMIT_SLOW[PRE_W-1:0];
  assign tick = run && !clear && (count == limit);

  always @(posedge clock or posedge rst) begin
    if (rst) begin
      count <= {PRE_W{1'b0}};
    end else if (clear || tick) begin
      count <= {PRE_W{1'b0}};
    end else if (run) begin
      count <= count + 1'b1;
    end
  end
endmodule

// >>> bench/wdt_top_monitor.sv
// Port assertions for the watchdog top
`timescale 1ns/1ns
module wdt_top_monitor (
  // Clock and reset
  input logic clock,
  input logic rst,
  // Instruction strobes
  input logic watchdog_disable_instruction,
  input logic watchdog_enable_instruction,
  input logic service,
  // Watched outputs
  input logic running,
  input logic prewarn_irq,
  input logic reset_request,
  input logic [15:0] count,
  input logic [7:0] watchdog_reload_value
);
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  sequence s_wrap; $past(count) == 16'hFFFF && count == 16'h0000; endsequence
  property p_boot; $fell(rst) |-> running; endproperty
  // A service right after the disable may still load the counter
  property p_off;
    watchdog_disable_instruction |=> !running ##1 ($stable(count) || $past(service));
  endproperty
  property p_on;
    watchdog_enable_instruction && !watchdog_disable_instruction |=> running;
  endproperty
  property p_svc; service |=> count == {$past(watchdog_reload_value), 8'h00}; endproperty
  property p_step; $changed(count) && !$past(service) |-> count - $past(count) == 16'h1; endproperty
  property p_gap;
    $changed(count) && !$past(service) |=> ($stable(count) || $past(service))[*8];
  endproperty
  property p_warn; prewarn_irq |-> s_wrap ##1 !prewarn_irq; endproperty
  property p_hold; reset_request |=> reset_request; endproperty
  a_boot: assert property (p_boot) else $error("boot");
  a_off: assert property (p_off) else $error("off");
  a_on: assert property (p_on) else $error("on");
  a_svc: assert property (p_svc) else $error("svc");
  a_step: assert property (p_step) else $error("step");
  a_gap: assert property (p_gap) else $error("gap");
  a_warn: assert property (p_warn) else $error("warn");
  a_hold: assert property (p_hold) else $error("hold");
endmodule

// >>> bench/wdt_top_tb.sv
// Self-checking bench for the watchdog top
`timescale 1ns/1ns
module wdt_top_tb;
  logic clock = 0, rst = 1, pf = 1, running, irq, rr, fast;
  logic [4:0] st = 0;
  logic [7:0] rv = 8'h80, rl;
  logic [15:0] count, c;
  int n_mismatch = 0, tests_run = 0, cyc = 0, k;
  always #50 clock = ~clock;
  wdt_top #(.WARN_TICKS(8'h02)) u_dut (.clock(clock), .rst(rst),
    .watchdog_disable_instruction(st[0]), .watchdog_enable_instruction(st[1]),
    .service(st[2]), .reload_write(st[3]), .watchdog_reload_value_in(rv),
    .prescale_write(st[4]), .prescale_fast_in(pf), .running(running), .count(count),
    .prewarn_irq(irq), .reset_request(rr), .watchdog_reload_value(rl), .prescale_fast(fast));
  task chk(string n, logic [15:0] g, logic [15:0] e);
    tests_run++;
    if (g !== e) begin
      $display("MISMATCH %s exp %h got %h", n, e, g);
      n_mismatch++;
    end
  endtask
  task go(logic [4:0] s);
    @(negedge clock) st = s;
    @(negedge clock) st = 0;
  endtask
  task gap;
    c = count;
    k = 0;
    while (count === c && k < 70000) begin
      @(negedge clock);
      k++;
    end
  endtask
  task report_and_stop;
    $display("runs %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task t_count;
    chk("run", running, 1);
    chk("cnt", count, 16'hFF03);
    chk("fast", fast, 1);
    gap;
    chk("cnt", count, 16'hFF04);
    gap;
    chk("gap", k, 256);
    $display("count done");
  endtask
  task t_cfg;
    repeat (10) @(negedge clock);
    go(5'h08);
    chk("rel", rl, 8'h80);
    pf = 0;
    go(5'h10);
    chk("fast", fast, 0);
    go(5'h04);
    gap;
    chk("slow", k, 16384);
    chk("cnt", count, 16'h8001);
    pf = 1;
    rv = 8'hFF;
    go(5'h18);
    go(5'h04);
    chk("cnt", count, 16'hFF00);
    go(5'h01);
    chk("run", running, 0);
    c = count;
    repeat (300) @(negedge clock);
    chk("held", count, c);
    go(5'h02);
    chk("run", running, 1);
    $display("cfg done");
  endtask
  task t_end;
    k = 0;
    while (irq !== 1'b1 && k < 70000) begin
      @(negedge clock);
      k++;
    end
    chk("irq", irq, 1);
    chk("wrap", count, 0);
    repeat (10) @(negedge clock);
    go(5'h04);
    repeat (300) @(negedge clock);
    chk("req", rr, 0);
    repeat (300) @(negedge clock);
    chk("req", rr, 1);
    rst = 1;
    @(negedge clock) rst = 0;
    chk("req", rr, 0);
    chk("cnt", count, 16'hFF03);
    $display("end done");
  endtask
  always @(posedge clock) if (++cyc == 90000) begin
    n_mismatch++;
    report_and_stop;
  end
  initial begin
    repeat (5) @(negedge clock);
    rst = 0;
    t_count;
    t_cfg;
    t_end;
    report_and_stop;
  end
endmodule
bind wdt_top wdt_top_monitor u_mon (.clock(clock), .rst(rst), .service(service),
  .watchdog_disable_instruction(watchdog_disable_instruction), .running(running),
  .watchdog_enable_instruction(watchdog_enable_instruction), .count(count),
  .prewarn_irq(prewarn_irq), .reset_request(reset_request),
  .watchdog_reload_value(watchdog_reload_value));
